// file: sal_params.svh
// constants for the shared add-bus / line-clock pin block
`ifndef SAL_PARAMS_SVH
`define SAL_PARAMS_SVH

// apb widths
`define SAL_AW 18
`define SAL_DW 32

// per-channel i/o control registers: printed offsets are word indices
`define SAL_IO2_IDX 16'h3F01
`define SAL_IO6_IDX 16'h7F01
`define SAL_IO2_ADDR {`SAL_IO2_IDX, 2'b00}
`define SAL_IO6_ADDR {`SAL_IO6_IDX, 2'b00}

// block control and status registers
`define SAL_CTRL_ADDR 18'h00000
`define SAL_ADD_STAT_ADDR 18'h00004
`define SAL_LINE_STAT_ADDR 18'h00008

// field positions and widths
`define SAL_EDGE_SEL_BIT 1
`define SAL_IO_W 8
`define SAL_CTRL_W 3

// reset values
`define SAL_IO_RST 8'h00
`define SAL_CTRL_RST 3'h0
`define SAL_BYTE_RST 8'h00

`endif

// file: sal_pkg.sv
// types shared by the shared-pin block
package sal_pkg;

    // role of the two shared pins
    typedef enum logic {
        SAL_ROLE_LINE,
        SAL_ROLE_ADD
    } sal_role_t;

    // software control word
    typedef struct packed {
        logic [1:0] sts1;
        logic       bus_en;
    } sal_ctrl_t;

    // one captured line bit
    typedef struct packed {
        logic data;
        logic valid;
    } sal_line_t;

endpackage

// file: sal_line_cap.sv
// recovered-clock line data capture for one tributary channel
`timescale 1ns/1ps
module sal_line_cap (
    // clock and reset
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    // control
    input  wire logic          enable_in,
    input  wire logic          rise_sel_in,
    // pins from the line interface unit
    input  wire logic          clk_pin_in,
    input  wire logic          data_pin_in,
    // captured bit
    output sal_pkg::sal_line_t cap_out
);

    logic [2:0] ck_r;
    logic [1:0] dt_r;
    logic [2:0] fill_r;
    logic       rise_w;
    logic       fall_w;
    logic       hit_w;

    // two-flop synchronisers, third clock stage only for edge detection
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ck_r   <= 3'h0;
            dt_r   <= 2'h0;
            fill_r <= 3'h0;
        end else begin
            ck_r   <= {ck_r[1:0], clk_pin_in};
            dt_r   <= {dt_r[0], data_pin_in};
            fill_r <= {fill_r[1:0], 1'b1};
        end
    end

    // data is delayed exactly like the clock, so their phase is kept
    assign rise_w = ck_r[1] & ~ck_r[2];
    assign fall_w = ~ck_r[1] & ck_r[2];
    // edges count only once the chain holds real pin values, so the
    // cleared chain cannot fake an edge just after reset
    assign hit_w  = enable_in & fill_r[2] &
                    (rise_sel_in ? rise_w : fall_w); // R7 R8 R9

    // capture on the selected edge; data holds between captures
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cap_out <= '0;
        end else begin
            cap_out.valid <= hit_w;
            if (hit_w) begin
                cap_out.data <= dt_r[1];
            end
        end
    end

    property p_cap_fall;
        @(posedge clk_in) disable iff (rst_in)
        enable_in && !rise_sel_in && fall_w
        |=> cap_out.valid && cap_out.data == $past(dt_r[1]);
    endproperty
    a_cap_fall: assert property (p_cap_fall) // R7
        else $error("falling edge not captured");

    property p_cap_rise;
        @(posedge clk_in) disable iff (rst_in)
        cap_out.valid && $past(rise_sel_in)
        |-> $past(ck_r[1]) && !$past(ck_r[2]);
    endproperty
    a_cap_rise: assert property (p_cap_rise) // R8 R9
        else $error("capture not on rising edge");

    property p_cap_gate;
        @(posedge clk_in) disable iff (rst_in)
        !enable_in |=> !cap_out.valid;
    endproperty
    a_cap_gate: assert property (p_cap_gate) // R1
        else $error("capture while disabled");

    c_cap_rise: cover property (@(posedge clk_in) disable iff (rst_in)
        rise_sel_in && rise_w && enable_in);

endmodule

// file: sal_pinmux.sv
// shared add-bus data / recovered line clock pins with apb control
//
// Overview of operation
// R1: role of shared pins follows channel 2 add-bus enable: bus bit or clock
// R2: with bus enabled, first shared pin is add data bit 5
// R3: with bus enabled, second shared pin is add data bit 6
// R4: add data bits sampled on falling edge of add-bus clock
// R5: bus disabled: first pin clocks channel 2, second clocks channel 6
// R6: line interface unit drives each pin from its recovered clock
// R7: line data captured on recovered clock falling edge by default
// R8: channel 2 control bit 1 set selects rising edge for ds3/e3
// R9: channel 6 control bit 1 set selects rising edge for ds3/e3
// R10: sts-1 operation always captures on falling edge
// R11: edge select bits reset to zero, so falling edge applies
`timescale 1ns/1ps
`include "sal_params.svh"
module sal_pinmux (
    // system clock and reset
    input  wire logic                CLK_IN,
    input  wire logic                RST_IN,
    // apb slave
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [`SAL_AW-1:0]  PADDR,
    input  wire logic [`SAL_DW-1:0]  PWDATA,
    output logic      [`SAL_DW-1:0]  PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    // add-bus link
    input  wire logic                ADD_CLK_IN,
    input  wire logic                ADD_HI_IN,
    input  wire logic [4:0]          ADD_LO_IN,
    // shared pins and line data pins, index 0 channel 2, 1 channel 6
    input  wire logic [1:0]          SHARED_PIN_IN,
    input  wire logic [1:0]          LINE_DATA_IN,
    // add-bus bytes
    output logic [7:0]               ADD_DATA_OUT,
    output logic                     ADD_VALID_OUT,
    // line bits
    output logic [1:0]               LINE_DATA_OUT,
    output logic [1:0]               LINE_VALID_OUT
);

    // one-hot register select: ctrl, add status, line status, io2, io6
    function automatic logic [4:0] sal_dec(input logic [`SAL_AW-1:0] a);
        return {a == `SAL_IO6_ADDR,
                a == `SAL_IO2_ADDR,
                a == `SAL_LINE_STAT_ADDR,
                a == `SAL_ADD_STAT_ADDR,
                a == `SAL_CTRL_ADDR};
    endfunction

    sal_pkg::sal_ctrl_t   ctrl_r;
    logic [`SAL_IO_W-1:0] io2_r;
    logic [`SAL_IO_W-1:0] io6_r;
    logic [4:0]           sel_w;
    logic                 mapped_w;
    logic                 access_w;
    logic                 done_w;
    logic                 wr_w;
    logic [`SAL_DW-1:0]   rdata_w;
    sal_pkg::sal_role_t   role_w;
    logic                 line_mode_w;
    logic [1:0]           rise_sel_w;
    logic [7:0]           add_word_w;
    logic [7:0]           add_byte_r;
    logic                 add_tgl_r;
    logic [2:0]           tgl_sync_r;
    logic                 add_evt_w;
    logic [7:0]           line_sh_r [2];
    sal_pkg::sal_line_t   cap_w [2];

    // apb decode: pready rises one cycle into the access phase
    assign sel_w    = sal_dec(PADDR);
    assign mapped_w = |sel_w;
    assign access_w = PSEL & PENABLE & ~PREADY;
    assign done_w   = PSEL & PENABLE & PREADY;
    assign wr_w     = done_w & PWRITE & mapped_w;

    // read mux; unmapped addresses read zero
    assign rdata_w =
        sel_w[0] ? {{(`SAL_DW-`SAL_CTRL_W){1'b0}}, ctrl_r} :
        sel_w[1] ? {24'h000000, ADD_DATA_OUT} :
        sel_w[2] ? {16'h0000, line_sh_r[1], line_sh_r[0]} :
        sel_w[3] ? {24'h000000, io2_r} :
        sel_w[4] ? {24'h000000, io6_r} :
        32'h00000000;

    // apb answer flops
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= access_w;
            PSLVERR <= access_w & ~mapped_w;
            if (access_w & ~PWRITE) begin
                PRDATA <= rdata_w;
            end
        end
    end

    // writes take effect only at the completing edge
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_r <= `SAL_CTRL_RST;
            io2_r  <= `SAL_IO_RST; // R11
            io6_r  <= `SAL_IO_RST; // R11
        end else begin
            if (wr_w & sel_w[0]) begin
                ctrl_r <= PWDATA[`SAL_CTRL_W-1:0];
            end
            if (wr_w & sel_w[3]) begin
                io2_r <= PWDATA[`SAL_IO_W-1:0];
            end
            if (wr_w & sel_w[4]) begin
                io6_r <= PWDATA[`SAL_IO_W-1:0];
            end
        end
    end

    // pin role and edge choice; sts-1 mode forces the falling edge
    assign role_w = ctrl_r.bus_en ? sal_pkg::SAL_ROLE_ADD
                                  : sal_pkg::SAL_ROLE_LINE; // R1
    assign line_mode_w = (role_w == sal_pkg::SAL_ROLE_LINE);
    assign rise_sel_w[0] = io2_r[`SAL_EDGE_SEL_BIT] & ~ctrl_r.sts1[0]; // R8 R10
    assign rise_sel_w[1] = io6_r[`SAL_EDGE_SEL_BIT] & ~ctrl_r.sts1[1]; // R9 R10

    // add byte: pin 0 is bit 5, pin 1 is bit 6
    assign add_word_w = {ADD_HI_IN, SHARED_PIN_IN[1], SHARED_PIN_IN[0],
                         ADD_LO_IN}; // R2 R3

    // link domain: sample on the falling edge, toggle marks a new byte
    always_ff @(negedge ADD_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            add_byte_r <= `SAL_BYTE_RST;
            add_tgl_r  <= 1'b0;
        end else begin
            add_byte_r <= add_word_w; // R4
            add_tgl_r  <= ~add_tgl_r;
        end
    end

    // toggle crossing; the byte is stable for a whole add clock period,
    // so the add clock must be slower than about four system cycles
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tgl_sync_r <= 3'h0;
        end else begin
            tgl_sync_r <= {tgl_sync_r[1:0], add_tgl_r};
        end
    end

    assign add_evt_w = tgl_sync_r[1] ^ tgl_sync_r[2];

    // add bytes are delivered only while the bus role is selected
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ADD_VALID_OUT <= 1'b0;
            ADD_DATA_OUT  <= `SAL_BYTE_RST;
        end else begin
            ADD_VALID_OUT <= add_evt_w & ~line_mode_w; // R1
            if (add_evt_w & ~line_mode_w) begin
                ADD_DATA_OUT <= add_byte_r;
            end
        end
    end

    // one capture unit per tributary, sampling its shared pin as the recovered clock
    for (genvar g = 0; g < 2; g++) begin : g_line
        sal_line_cap u_cap (
            .clk_in      (CLK_IN),
            .rst_in      (RST_IN),
            .enable_in   (line_mode_w),
            .rise_sel_in (rise_sel_w[g]),
            .clk_pin_in  (SHARED_PIN_IN[g]), // R5
            .data_pin_in (LINE_DATA_IN[g]),
            .cap_out     (cap_w[g])
        );
    end

    // line outputs and history shift registers for software
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            LINE_VALID_OUT <= 2'h0;
            LINE_DATA_OUT  <= 2'h0;
            line_sh_r[0]   <= `SAL_BYTE_RST;
            line_sh_r[1]   <= `SAL_BYTE_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                LINE_VALID_OUT[i] <= cap_w[i].valid & line_mode_w; // R5
                if (cap_w[i].valid & line_mode_w) begin
                    LINE_DATA_OUT[i] <= cap_w[i].data;
                    line_sh_r[i]     <= {line_sh_r[i][6:0], cap_w[i].data};
                end
            end
        end
    end

    property p_r1_role;
        @(posedge CLK_IN) disable iff (RST_IN)
        ctrl_r.bus_en |=> !LINE_VALID_OUT[0] && !LINE_VALID_OUT[1];
    endproperty
    a_r1_role: assert property (p_r1_role) // R1
        else $error("line bit delivered in bus role");

    property p_r1_drop;
        @(posedge CLK_IN) disable iff (RST_IN)
        !ctrl_r.bus_en |=> !ADD_VALID_OUT;
    endproperty
    a_r1_drop: assert property (p_r1_drop) // R1
        else $error("add byte delivered in line role");

    property p_r2_bit5;
        @(negedge ADD_CLK_IN) disable iff (RST_IN)
        1'b1 |=> add_byte_r[5] == $past(SHARED_PIN_IN[0]);
    endproperty
    a_r2_bit5: assert property (p_r2_bit5) // R2
        else $error("bit 5 not from first shared pin");

    property p_r3_bit6;
        @(negedge ADD_CLK_IN) disable iff (RST_IN)
        1'b1 |=> add_byte_r[6] == $past(SHARED_PIN_IN[1]);
    endproperty
    a_r3_bit6: assert property (p_r3_bit6) // R3
        else $error("bit 6 not from second shared pin");

    property p_r4_sample;
        @(negedge ADD_CLK_IN) disable iff (RST_IN)
        1'b1 |=> add_tgl_r != $past(add_tgl_r);
    endproperty
    a_r4_sample: assert property (p_r4_sample) // R4
        else $error("add byte not taken on falling edge");

    property p_r4_deliver;
        @(posedge CLK_IN) disable iff (RST_IN)
        add_evt_w && ctrl_r.bus_en
        |=> ADD_VALID_OUT && ADD_DATA_OUT == $past(add_byte_r);
    endproperty
    a_r4_deliver: assert property (p_r4_deliver) // R4
        else $error("add byte lost at crossing");

    // an add byte takes a whole add clock period, so valid never repeats
    property p_r4_pulse;
        @(posedge CLK_IN) disable iff (RST_IN)
        ADD_VALID_OUT |=> !ADD_VALID_OUT;
    endproperty
    a_r4_pulse: assert property (p_r4_pulse) // R4
        else $error("add valid held longer than one cycle");

    property p_r5_line;
        @(posedge CLK_IN) disable iff (RST_IN)
        !ctrl_r.bus_en && cap_w[1].valid
        |=> LINE_VALID_OUT[1] && LINE_DATA_OUT[1] == $past(cap_w[1].data);
    endproperty
    a_r5_line: assert property (p_r5_line) // R5
        else $error("channel 6 bit not delivered");

    property p_r5_ch2;
        @(posedge CLK_IN) disable iff (RST_IN)
        !ctrl_r.bus_en && cap_w[0].valid
        |=> LINE_VALID_OUT[0] && LINE_DATA_OUT[0] == $past(cap_w[0].data);
    endproperty
    a_r5_ch2: assert property (p_r5_ch2) // R5
        else $error("channel 2 bit not delivered");

    property p_r8_rise;
        @(posedge CLK_IN) disable iff (RST_IN)
        wr_w && sel_w[3] && PWDATA[1] && !ctrl_r.sts1[0] |=> rise_sel_w[0];
    endproperty
    a_r8_rise: assert property (p_r8_rise) // R8
        else $error("channel 2 rising edge not selected");

    property p_r9_rise;
        @(posedge CLK_IN) disable iff (RST_IN)
        wr_w && sel_w[4] && PWDATA[1] && !ctrl_r.sts1[1] |=> rise_sel_w[1];
    endproperty
    a_r9_rise: assert property (p_r9_rise) // R9
        else $error("channel 6 rising edge not selected");

    property p_r10_sts1;
        @(posedge CLK_IN) disable iff (RST_IN)
        ctrl_r.sts1 != 2'h0 |-> (rise_sel_w & ctrl_r.sts1) == 2'h0;
    endproperty
    a_r10_sts1: assert property (p_r10_sts1) // R10
        else $error("rising edge used in sts-1 mode");

    property p_r11_reset;
        @(posedge CLK_IN)
        $fell(RST_IN) |-> rise_sel_w == 2'h0;
    endproperty
    a_r11_reset: assert property (p_r11_reset) // R11
        else $error("edge select not cleared by reset");

    c_add_byte: cover property (@(posedge CLK_IN) disable iff (RST_IN)
        ADD_VALID_OUT);
    c_line_rise: cover property (@(posedge CLK_IN) disable iff (RST_IN)
        LINE_VALID_OUT[0] && rise_sel_w[0]);
    c_apb_err: cover property (@(posedge CLK_IN) disable iff (RST_IN)
        PREADY && PSLVERR);

endmodule

// file: sal_lineside_model.sv
// far-side model: add-bus source and line interface unit clocks/data
`timescale 1ns/1ps
module sal_lineside_model (
    // add-bus side
    output logic       add_clk_out,
    output logic       add_hi_out,
    output logic [4:0] add_lo_out,
    // shared pins and line data
    output logic [1:0] shared_out,
    output logic [1:0] line_data_out
);
    // idle: add clock parked low, recovered clocks parked high
    initial begin
        add_clk_out = 1'b0;
        {add_hi_out, add_lo_out} = 6'h00;
        shared_out = 2'h3;
        line_data_out = 2'h0;
    end

    // one byte per 55 ns clock, steady 24 ns either side of the fall
    task automatic send_byte(input logic [7:0] b);
        #7;
        {add_hi_out, shared_out, add_lo_out} = b;
        add_clk_out = 1'b1;
        #24 add_clk_out = 1'b0;
        #24;
        // hold over: show the inverse so a stale copy cannot pass
        {add_hi_out, shared_out, add_lo_out} = ~b;
    endtask

    // one clock low pulse; data a before the fall, b before the rise
    task automatic line_pair(input int ch, input logic a, input logic b);
        #7;
        line_data_out[ch] = a;
        #20 shared_out[ch] = 1'b0;
        #20 line_data_out[ch] = b;
        #20 shared_out[ch] = 1'b1;
        #20 line_data_out[ch] = ~b;
    endtask
endmodule

// file: tb_top.sv
// self-checking bench for the shared add-bus / line-clock pin block
`timescale 1ns/1ps
`include "sal_params.svh"
module tb_top;
    logic               clk = 1'b0;
    logic               rst = 1'b0;
    logic               psel = 1'b0;
    logic               penable = 1'b0;
    logic               pwrite = 1'b0;
    logic [`SAL_AW-1:0] paddr = '0;
    logic [`SAL_DW-1:0] pwdata = '0;
    logic [`SAL_DW-1:0] prdata;
    logic               pready;
    logic               pslverr;
    logic               add_clk;
    logic               add_hi;
    logic [4:0]         add_lo;
    logic [1:0]         shared;
    logic [1:0]         line_in;
    logic [7:0]         add_data;
    logic               add_valid;
    logic [1:0]         line_data;
    logic [1:0]         line_valid;
    int                 num_errors = 0;
    int                 num_checks = 0;
    int                 add_n = 0;
    int                 line_n [2] = '{0, 0};
    logic [7:0]         add_last = 8'h00;
    logic [1:0]         line_last = 2'h0;

    // 100 MHz system clock
    always #5 clk = ~clk;

    sal_pinmux dut_u (.CLK_IN(clk), .RST_IN(rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ADD_CLK_IN(add_clk), .ADD_HI_IN(add_hi), .ADD_LO_IN(add_lo),
        .SHARED_PIN_IN(shared), .LINE_DATA_IN(line_in),
        .ADD_DATA_OUT(add_data), .ADD_VALID_OUT(add_valid),
        .LINE_DATA_OUT(line_data), .LINE_VALID_OUT(line_valid));

    sal_lineside_model u_src (.add_clk_out(add_clk), .add_hi_out(add_hi),
        .add_lo_out(add_lo), .shared_out(shared),
        .line_data_out(line_in));

    // count output pulses and keep what came with them
    always @(posedge clk) begin
        if (add_valid === 1'b1) begin
            add_n <= add_n + 1;
            add_last <= add_data;
        end
        for (int c = 0; c < 2; c++) begin
            if (line_valid[c] === 1'b1) begin
                line_n[c] <= line_n[c] + 1;
                line_last[c] <= line_data[c];
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [17:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, pready}, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdchk(input logic [17:0] a, input logic [31:0] exp,
                         input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, ee});
    endtask

    // one clock pulse on a channel; exactly one capture expected
    task automatic line_case(input int ch, input logic a, input logic b,
                             input logic exp);
        int n0;
        n0 = line_n[ch];
        u_src.line_pair(ch, a, b);
        repeat (10) @(posedge clk);
        chk(line_n[ch] - n0, 32'h1);
        chk({31'h0, line_last[ch]}, {31'h0, exp});
    endtask

    task automatic add_case(input logic [7:0] b, input logic [31:0] cnt);
        int n0;
        n0 = add_n;
        u_src.send_byte(b);
        repeat (8) @(posedge clk);
        chk(add_n - n0, cnt);
        if (cnt != 0) chk({24'h0, add_last}, {24'h0, b});
    endtask

    task automatic t_regs;
        rdchk(`SAL_CTRL_ADDR, 32'h0, 1'b0);
        rdchk(`SAL_IO2_ADDR, 32'h0, 1'b0);
        rdchk(`SAL_IO6_ADDR, 32'h0, 1'b0);
        wr(`SAL_IO2_ADDR, 32'hFF);
        rdchk(`SAL_IO2_ADDR, 32'hFF, 1'b0);
        wr(`SAL_IO2_ADDR, 32'h00);
        rdchk(18'h00010, 32'h0, 1'b1);
    endtask

    task automatic t_line_default;
        line_case(0, 1'b1, 1'b0, 1'b1);
        line_case(1, 1'b0, 1'b1, 1'b0);
    endtask

    task automatic t_line_rising;
        wr(`SAL_IO2_ADDR, 32'h02);
        wr(`SAL_IO6_ADDR, 32'h02);
        rdchk(`SAL_IO6_ADDR, 32'h02, 1'b0);
        line_case(0, 1'b1, 1'b0, 1'b0);
        line_case(1, 1'b0, 1'b1, 1'b1);
    endtask

    // sts-1 bit per channel overrides the rising-edge choice
    task automatic t_line_sts1;
        wr(`SAL_CTRL_ADDR, 32'h2);
        line_case(0, 1'b0, 1'b1, 1'b0);
        line_case(1, 1'b1, 1'b0, 1'b0);
        wr(`SAL_CTRL_ADDR, 32'h4);
        rdchk(`SAL_CTRL_ADDR, 32'h4, 1'b0);
        line_case(0, 1'b0, 1'b1, 1'b1);
        line_case(1, 1'b1, 1'b0, 1'b1);
        // history, newest in bit 0: ch2 1,0,0,1 and ch6 0,1,0,1
        rdchk(`SAL_LINE_STAT_ADDR, 32'h0509, 1'b0);
    endtask

    task automatic t_add_bus;
        int l0;
        int l1;
        wr(`SAL_CTRL_ADDR, 32'h1);
        l0 = line_n[0];
        l1 = line_n[1];
        add_case(8'h20, 32'h1);
        add_case(8'h40, 32'h1);
        add_case(8'hA5, 32'h1);
        add_case(8'h5A, 32'h1);
        chk(line_n[0] - l0, 32'h0);
        chk(line_n[1] - l1, 32'h0);
        rdchk(`SAL_ADD_STAT_ADDR, 32'h5A, 1'b0);
    endtask

    task automatic t_add_dropped;
        wr(`SAL_CTRL_ADDR, 32'h0);
        add_case(8'h3C, 32'h0);
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a real rising edge of reset reaches the add-clock flops as well
    initial begin
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_line_default();
        t_line_rising();
        t_line_sts1();
        t_add_bus();
        t_add_dropped();
        summarize();
    end

    // the run needs a few microseconds; this only cuts a hang short
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
endmodule
